//--- rtl/ortp_param_table.sv
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`include "ortp_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module ortp_param_table
    import ortp_pkg::*;
#(
    parameter logic [7:0] OP_118 = 8'h8b,
    parameter logic [2:0] MODE_118 = 3'h0,
    parameter logic [4:0] DUMMY_118 = 5'h08,
    parameter logic [7:0] OP_188 = 8'hcb,
    parameter logic [2:0] MODE_188 = 3'h0,
    parameter logic [4:0] DUMMY_188 = 5'h10,
    parameter logic [6:0] STW_DESC = 7'h08,
    parameter logic [7:0] SR1_NV_RESET = 8'h00
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Constant parameter word

    // Pack the word once; all fields are elaboration constants
    function automatic logic [31:0] pack_params(input logic [7:0] op8, input logic [2:0] m8,
                                               input logic [4:0] d8, input logic [7:0] op88,
                                               input logic [2:0] m88, input logic [4:0] d88);
        logic [31:0] w;
        w = '0;
        w[`ORTP_F118_OP_HI:`ORTP_F118_OP_LO] = op8;
        w[`ORTP_F118_MODE_HI:`ORTP_F118_MODE_LO] = m8;
        w[`ORTP_F118_DUMMY_HI:`ORTP_F118_DUMMY_LO] = d8;
        w[`ORTP_F188_OP_HI:`ORTP_F188_OP_LO] = op88;
        w[`ORTP_F188_MODE_HI:`ORTP_F188_MODE_LO] = m88;
        w[`ORTP_F188_DUMMY_HI:`ORTP_F188_DUMMY_LO] = d88;
        return w;
    endfunction : pack_params

    // Unwritable status register must show zeros in the low five bits
    function automatic logic [6:0] clean_desc(input logic [6:0] d);
        logic [6:0] r;
        r = d;
        if ((d & `ORTP_STW_LOW_MASK) == 7'h00) begin
            r = d & ~`ORTP_STW_LOW_MASK;
        end
        return r;
    endfunction : clean_desc

    localparam logic [31:0] PARAM_WORD = pack_params(OP_118, MODE_118, DUMMY_118,
                                                     OP_188, MODE_188, DUMMY_188);
    localparam logic [6:0] DESC = clean_desc(STW_DESC);
    localparam bit SR1_WRITABLE = (DESC & `ORTP_STW_LOW_MASK) != 7'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave

    ortp_bus_t state_r;
    logic req;
    logic wr_stb;
    logic hit;
    logic [31:0] rdata_nxt;
    logic [7:0] opcode_r;
    logic wel_r;
    logic use_vol_r;
    logic [7:0] sr1_q;
    logic sr1_wr_nv;
    logic sr1_wr_vol;
    ortp_we_t armed;

    assign req = wb_cyc_i && wb_stb_i && (state_r == ORTP_IDLE);
    assign wr_stb = req && wb_we_i && wb_sel_i[0];

    always_comb begin
        hit = 1'b1;
        rdata_nxt = 32'h0000_0000;
        case (wb_adr_i)
            `ORTP_OFF_PARAMS: rdata_nxt = PARAM_WORD;
            `ORTP_OFF_STWEN: rdata_nxt = {25'h0000000, DESC};
            `ORTP_OFF_SR1_CTRL: rdata_nxt = {22'h000000, use_vol_r, wel_r, opcode_r};
            `ORTP_OFF_SR1_STAT: rdata_nxt = {24'h000000, sr1_q};
            `ORTP_OFF_OPCODE: rdata_nxt = {24'h000000, opcode_r};
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= ORTP_IDLE;
        end else begin
            case (state_r)
                ORTP_IDLE: if (wb_cyc_i && wb_stb_i) state_r <= ORTP_ACK;
                ORTP_ACK: state_r <= ORTP_IDLE;
                default: state_r <= ORTP_IDLE;
            endcase
        end
    end

    // Answer one cycle after the request; error on unmapped addresses
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req && hit;
            wb_err_o <= req && !hit;
            if (req && !wb_we_i) begin
                wb_dat_o <= rdata_nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status register write enable

    // Which opcode arms which copy depends on the descriptor
    function automatic ortp_we_t decode_we(input logic [7:0] op, input logic [6:0] d);
        ortp_we_t r;
        r = ORTP_WE_NONE;
        if (op == `ORTP_OP_WREN && (d[`ORTP_STW_NV_06] || d[`ORTP_STW_NVV] || d[`ORTP_STW_MIX])) begin
            r = ORTP_WE_NV;
        end else if (op == `ORTP_OP_WREN && d[`ORTP_STW_V_06]) begin
            r = ORTP_WE_VOL;
        end else if (op == `ORTP_OP_VWREN && (d[`ORTP_STW_V_50] || d[`ORTP_STW_NVV])) begin
            r = ORTP_WE_VOL;
        end
        return r;
    endfunction : decode_we

    assign armed = decode_we(opcode_r, DESC);

    // Writes to the parameter word and descriptor decode to nothing
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            opcode_r <= 8'h00;
        end else if (wr_stb && wb_adr_i == `ORTP_OFF_OPCODE) begin
            opcode_r <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wel_r <= 1'b0;
        end else if (wr_stb && wb_adr_i == `ORTP_OFF_OPCODE) begin
            wel_r <= SR1_WRITABLE && decode_we(wb_dat_i[7:0], DESC) != ORTP_WE_NONE;
        end else if (sr1_wr_nv || sr1_wr_vol) begin
            wel_r <= 1'b0;
        end
    end

    // Volatile override activated by 50h on a combined register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            use_vol_r <= DESC[`ORTP_STW_V_06] || DESC[`ORTP_STW_V_50];
        end else if (wr_stb && wb_adr_i == `ORTP_OFF_OPCODE && wb_dat_i[7:0] == `ORTP_OP_VWREN &&
                     DESC[`ORTP_STW_NVV]) begin
            use_vol_r <= 1'b1;
        end
    end

    assign sr1_wr_nv = wr_stb && wb_adr_i == `ORTP_OFF_SR1_STAT && wel_r && armed == ORTP_WE_NV;
    assign sr1_wr_vol = wr_stb && wb_adr_i == `ORTP_OFF_SR1_STAT && wel_r && armed == ORTP_WE_VOL;

    ortp_sr1_store #(
        .WIDTH(8),
        .NV_RESET(SR1_NV_RESET)
    ) u_sr1 (
        .clk(clk),
        .reset(reset),
        .wr_nv(sr1_wr_nv),
        .wr_vol(sr1_wr_vol),
        .use_vol(use_vol_r),
        .wdata(wb_dat_i[7:0]),
        .rdata(sr1_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence param_read_s;
        req && !wb_we_i && wb_adr_i == `ORTP_OFF_PARAMS;
    endsequence

    param_read_const_a: assert property (@(posedge clk) disable iff (reset)
        param_read_s |=> wb_ack_o && wb_dat_o == PARAM_WORD)
        else $error("parameter word read returned wrong data");

    opcode_118_a: assert property (@(posedge clk) disable iff (reset)
        param_read_s |=> wb_dat_o[31:24] == OP_118)
        else $error("1-1-8 opcode field wrong");

    mode_118_a: assert property (@(posedge clk) disable iff (reset)
        param_read_s |=> wb_dat_o[23:21] == MODE_118)
        else $error("1-1-8 mode field wrong");

    dummy_118_a: assert property (@(posedge clk) disable iff (reset)
        param_read_s |=> wb_dat_o[20:16] == DUMMY_118)
        else $error("1-1-8 dummy field wrong");

    opcode_188_a: assert property (@(posedge clk) disable iff (reset)
        param_read_s |=> wb_dat_o[15:8] == OP_188)
        else $error("1-8-8 opcode field wrong");

    mode_188_a: assert property (@(posedge clk) disable iff (reset)
        param_read_s |=> wb_dat_o[7:5] == MODE_188)
        else $error("1-8-8 mode field wrong");

    dummy_188_a: assert property (@(posedge clk) disable iff (reset)
        param_read_s |=> wb_dat_o[4:0] == DUMMY_188)
        else $error("1-8-8 dummy field wrong");

    ro_desc_zero_a: assert property (@(posedge clk) disable iff (reset)
        !SR1_WRITABLE |-> !wel_r)
        else $error("read-only status register became write enabled");

    mixed_wren_a: assert property (@(posedge clk) disable iff (reset)
        (wr_stb && wb_adr_i == `ORTP_OFF_OPCODE && wb_dat_i[7:0] == `ORTP_OP_WREN && DESC[`ORTP_STW_MIX])
        |=> wel_r)
        else $error("06h did not enable mixed status register");

    vol_override_a: assert property (@(posedge clk) disable iff (reset)
        (wr_stb && wb_adr_i == `ORTP_OFF_OPCODE && wb_dat_i[7:0] == `ORTP_OP_VWREN && DESC[`ORTP_STW_NVV])
        |=> use_vol_r ##1 use_vol_r)
        else $error("50h did not activate volatile copy");

    ack_one_cycle_a: assert property (@(posedge clk) disable iff (reset)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

endmodule : ortp_param_table

//--- rtl/ortp_regs.svh
`ifndef ORTP_REGS_SVH
`define ORTP_REGS_SVH

// Register byte offsets
`define ORTP_OFF_PARAMS     8'h00
`define ORTP_OFF_STWEN      8'h04
`define ORTP_OFF_SR1_CTRL   8'h08
`define ORTP_OFF_SR1_STAT   8'h0c
`define ORTP_OFF_OPCODE     8'h10

// Parameter word field positions
`define ORTP_F118_OP_HI     31
`define ORTP_F118_OP_LO     24
`define ORTP_F118_MODE_HI   23
`define ORTP_F118_MODE_LO   21
`define ORTP_F118_DUMMY_HI  20
`define ORTP_F118_DUMMY_LO  16
`define ORTP_F188_OP_HI     15
`define ORTP_F188_OP_LO     8
`define ORTP_F188_MODE_HI   7
`define ORTP_F188_MODE_LO   5
`define ORTP_F188_DUMMY_HI  4
`define ORTP_F188_DUMMY_LO  0

// Status write-enable descriptor bits
`define ORTP_STW_NV_06      0
`define ORTP_STW_V_06       1
`define ORTP_STW_V_50       2
`define ORTP_STW_NVV        3
`define ORTP_STW_MIX        4
`define ORTP_STW_LOW_MASK   7'h1f

// Opcodes that enable status writes
`define ORTP_OP_WREN        8'h06
`define ORTP_OP_VWREN       8'h50

// Reset value of the status register
`define ORTP_SR1_RESET      8'h00

`endif

//--- rtl/ortp_pkg.sv
package ortp_pkg;
    typedef enum logic [1:0] {
        ORTP_WE_NONE,
        ORTP_WE_NV,
        ORTP_WE_VOL
    } ortp_we_t;

    typedef enum {
        ORTP_IDLE,
        ORTP_ACK
    } ortp_bus_t;
endpackage : ortp_pkg

//--- rtl/ortp_sr1_store.sv
`timescale 1ns/1ps
// Small store for the status register: non-volatile copy and volatile overlay.
module ortp_sr1_store
    import ortp_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter logic [7:0] NV_RESET = 8'h00
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic wr_nv,
    input wire logic wr_vol,
    input wire logic use_vol,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] nv_r;
    logic [WIDTH-1:0] vol_r;

    // The non-volatile copy is not cleared by reset in a real part; here it
    // takes its power-up value so that simulation starts defined.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            nv_r <= NV_RESET[WIDTH-1:0];
        end else if (wr_nv) begin
            nv_r <= wdata;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            vol_r <= '0;
        end else if (wr_vol) begin
            vol_r <= wdata;
        end else if (!use_vol) begin
            vol_r <= nv_r;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata <= '0;
        end else begin
            rdata <= use_vol ? vol_r : nv_r;
        end
    end
endmodule : ortp_sr1_store

//--- test/ortp_wb_host.sv
`timescale 1ns/1ps
// Register-bus host standing in for the controller that reads the parameter words
module ortp_wb_host (
    input wire logic clk,
    output logic cyc,
    output logic stb,
    output logic we,
    output logic [7:0] adr,
    output logic [3:0] sel,
    output logic [31:0] dat,
    input wire logic [31:0] rdat,
    input wire logic ack,
    input wire logic err
);
    initial begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        dat = 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One classic cycle; gives up after 50 edges so a dead slave cannot hang the run
    task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q, output logic er);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        dat <= d;
        n = 0;
        er = 1'b1;
        q = 32'h0;
        do begin
            @(posedge clk);
            n++;
        end while (!(ack === 1'b1 || err === 1'b1) && n < 50);
        if (n < 50) begin
            q = rdat;
            er = err;
        end
        // Released lines show the inverse of their last value, never a held copy
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= ~w;
        adr <= ~a;
        sel <= 4'h0;
        dat <= ~d;
    endtask : access
endmodule : ortp_wb_host

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
    import ortp_pkg::*;
    localparam logic [7:0] OP8 = 8'h8b;
    localparam logic [7:0] OP88 = 8'hcb;
    localparam logic [6:0] DESC = 7'h08;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cyc, stb, we, ack, err, ack_ro, err_ro, e;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, rdat_ro, got, v;
    logic ack_mx, err_mx;
    logic [31:0] rdat_mx;
    logic [31:0] seed = 32'h8475;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;

    ortp_wb_host host (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(wdat),
        .rdat(rdat), .ack(ack), .err(err));
    ortp_param_table #(.OP_118(OP8), .MODE_118(3'h4), .DUMMY_118(5'h08), .OP_188(OP88), .MODE_188(3'h1),
        .DUMMY_188(5'h02), .STW_DESC(DESC)) dut (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .wb_err_o(err));
    // Read-only status register variant shadows the same bus traffic
    ortp_param_table #(.STW_DESC(7'h00)) dut_ro (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat_ro), .wb_ack_o(ack_ro),
        .wb_err_o(err_ro));
    // Mixed volatile/non-volatile variant: 06h alone must arm writes
    ortp_param_table #(.STW_DESC(7'h10)) dut_mx (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat_mx), .wb_ack_o(ack_mx),
        .wb_err_o(err_mx));

    initial begin
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    // Clocks spent on a field given in bits, carried on the given number of wires
    function automatic logic [7:0] clks(input int bits, input int wires);
        return 8'(bits / wires);
    endfunction : clks

    function automatic logic [31:0] exp_param();
        return {OP8, 3'(clks(4, 1)), 5'(clks(8, 1)), OP88, 3'(clks(8, 8)), 5'(clks(16, 8))};
    endfunction : exp_param

    task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] seen);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk_word

    task automatic chk_bit(input string name, input logic exp, input logic seen);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %b seen %b", name, exp, seen);
        end
    endtask : chk_bit

    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        host.access(1'b0, 8'h00, 32'h0, got, e);
        chk_word("param", exp_param(), got);
        chk_bit("param_err", 1'b0, e);
        chk_bit("dummy_nonzero", 1'b1, (got[20:16] != 5'h00) && (got[4:0] != 5'h00));
        // Random writes, each followed by a read of the word, must never disturb the constant word
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            host.access(1'b1, 8'h00, seed, got, e);
            host.access(1'b0, 8'h00, 32'h0, got, e);
            chk_word("param_after_write", exp_param(), got);
        end
        host.access(1'b0, 8'h04, 32'h0, got, e);
        chk_word("desc", {25'h0, DESC}, got);
        chk_word("desc_ro_low", 32'h0, rdat_ro & 32'h1f);
        seed = xs(seed);
        v = {24'h0, seed[7:0]};
        host.access(1'b1, 8'h0c, v, got, e);
        host.access(1'b0, 8'h0c, 32'h0, got, e);
        // Only bits 7:2 of the stored status byte are compared; bits 1:0 are masked off
        chk_word("sr1_locked", 32'h0, {26'h0, got[7:2]});
        host.access(1'b1, 8'h10, 32'h06, got, e);
        host.access(1'b0, 8'h08, 32'h0, got, e);
        chk_word("ctrl_nv", 32'h106, got);
        chk_bit("ro_wel", 1'b0, rdat_ro[8]);
        chk_bit("mixed_wel", 1'b1, rdat_mx[8]);
        host.access(1'b1, 8'h0c, v, got, e);
        host.access(1'b0, 8'h0c, 32'h0, got, e);
        chk_word("sr1_nv", {26'h0, v[7:2]}, {26'h0, got[7:2]});
        host.access(1'b0, 8'h08, 32'h0, got, e);
        chk_word("ctrl_wel_clear", 32'h006, got);
        host.access(1'b1, 8'h10, 32'h50, got, e);
        host.access(1'b0, 8'h08, 32'h0, got, e);
        chk_word("ctrl_vol", 32'h350, got);
        seed = xs(seed);
        host.access(1'b1, 8'h0c, seed, got, e);
        host.access(1'b0, 8'h0c, 32'h0, got, e);
        chk_word("sr1_vol", {26'h0, seed[7:2]}, {26'h0, got[7:2]});
        host.access(1'b0, 8'h14, 32'h0, got, e);
        chk_bit("unmapped_err", 1'b1, e);
        print_verdict();
    end
endmodule : tb
